// *** lpc_linkage_ctrl.sv ***
// Function
// - program inputs and outputs only in linkage
// - remote power-on works in any mode
// - remote shutdown works in any mode
// - stopped output after power-on
// - alive output; host waits ten seconds
// - home held until arrival sets at-home
// - start: running on, stopped and home off
// - pause toggles between running and paused
// - collision pauses; clear then pause resumes
// - clear input drops pending warning
// - stop: running off, stopped on
// - drag teach follows its enable input while powered
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

module lpc_linkage_ctrl
    import lpc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_linkage_mode,
    input wire logic i_prog_start_in,
    input wire logic i_prog_stop_in,
    input wire logic i_prog_pause_in,
    input wire logic i_go_home_in,
    input wire logic i_remote_power_on_in,
    input wire logic i_remote_shutdown_in,
    input wire logic i_warn_clear_in,
    input wire logic i_drag_teach_en_in,
    input wire logic i_sw_ready,
    input wire logic i_collision,
    input wire logic i_home_reached,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_power_en,
    output logic o_motion_en,
    output logic o_homing,
    output logic o_drag_mode,
    output logic o_warn_pending,
    output logic o_host_ready,
    output logic o_prog_running_out,
    output logic o_prog_stopped_out,
    output logic o_prog_paused_out,
    output logic o_at_home_out,
    output logic o_sw_alive_out
);

    localparam int NIN = `LPC_NUM_IN;
    localparam logic [`LPC_CNT_W-1:0] DB_CYC = `LPC_CNT_W'(`LPC_DEBOUNCE_CYC);

    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] filt_r;
    logic [NIN-1:0] filt_nxt;
    logic [NIN-1:0] prev_r;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] chg;

    assign raw_in = {i_drag_teach_en_in, i_warn_clear_in, i_remote_shutdown_in, i_remote_power_on_in,
                     i_go_home_in, i_prog_pause_in, i_prog_stop_in, i_prog_start_in};

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else if (i_ce)
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    // one debounce counter per input; a level must hold steady before it is accepted
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++)
        begin : g_db
            logic [`LPC_CNT_W-1:0] cnt_r;
            logic [`LPC_CNT_W-1:0] cnt_nxt;
            always_comb
            begin
                cnt_nxt = '0;
                filt_nxt[gi] = filt_r[gi];
                if (sync2_r[gi] != filt_r[gi])
                begin
                    cnt_nxt = cnt_r + `LPC_CNT_W'(1);
                    if (cnt_nxt >= DB_CYC)
                    begin
                        filt_nxt[gi] = sync2_r[gi];
                        cnt_nxt = '0;
                    end
                end
            end
            always_ff @(posedge i_core_clk)
            begin
                if (!i_rst_n)
                    cnt_r <= '0;
                else if (i_ce)
                    cnt_r <= cnt_nxt;
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            filt_r <= '0;
            prev_r <= '0;
        end
        else if (i_ce)
        begin
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    assign rise = filt_r & ~prev_r & {NIN{i_ce}};
    // latching switches toggle each press, so any level change is one press
    assign chg = (filt_r ^ prev_r) & {NIN{i_ce}};

    logic ev_start;
    logic ev_stop;
    logic ev_pause;
    logic ev_pwr_on;
    logic ev_shut;
    logic ev_clear;
    assign ev_start = rise[`LPC_IN_START];
    assign ev_stop = rise[`LPC_IN_STOP];
    assign ev_pause = chg[`LPC_IN_PAUSE];
    assign ev_pwr_on = rise[`LPC_IN_PWR_ON];
    assign ev_shut = rise[`LPC_IN_SHUTDOWN];
    assign ev_clear = rise[`LPC_IN_CLEAR];

    logic home_hold;
    assign home_hold = filt_r[`LPC_IN_HOME];

    // program state
    lpc_state_t st_r;
    lpc_state_t st_nxt;
    logic at_home_r;
    logic at_home_nxt;
    logic warn_r;
    logic warn_nxt;
    logic alive_r;
    logic alive_nxt;
    logic [`LPC_CNT_W-1:0] wait_r;
    logic [`LPC_CNT_W-1:0] wait_nxt;
    logic link;
    logic collide_ev;
    logic arrive_ev;

    assign link = i_linkage_mode;

    always_comb
    begin
        st_nxt = st_r;
        at_home_nxt = at_home_r;
        warn_nxt = warn_r;
        alive_nxt = alive_r;
        wait_nxt = wait_r;
        collide_ev = 1'b0;
        arrive_ev = 1'b0;
        if (ev_clear)
            warn_nxt = 1'b0;
        if (i_ce && st_r != LPC_OFF && i_sw_ready && !alive_r)
            alive_nxt = 1'b1;
        if (i_ce && alive_r && wait_r != '0)
            wait_nxt = wait_r - `LPC_CNT_W'(1);
        case (st_r)
            LPC_OFF:
            begin
                if (ev_pwr_on)
                begin
                    st_nxt = LPC_STOPPED;
                    wait_nxt = `LPC_CNT_W'(`LPC_ALIVE_WAIT_CYC);
                end
            end
            LPC_STOPPED:
            begin
                if (link && ev_start)
                begin
                    st_nxt = LPC_RUNNING;
                    at_home_nxt = 1'b0;
                end
                else if (link && home_hold && !at_home_r)
                    st_nxt = LPC_HOMING;
            end
            LPC_HOMING:
            begin
                if (i_ce && i_home_reached)
                begin
                    st_nxt = LPC_STOPPED;
                    at_home_nxt = 1'b1;
                    arrive_ev = 1'b1;
                end
                else if (!home_hold || !link || ev_stop)
                    st_nxt = LPC_STOPPED;
            end
            LPC_RUNNING:
            begin
                if (link && ev_stop)
                    st_nxt = LPC_STOPPED;
                else if (i_ce && i_collision)
                begin
                    st_nxt = LPC_COLLIDED;
                    warn_nxt = 1'b1;
                    collide_ev = 1'b1;
                end
                else if (link && ev_pause)
                    st_nxt = LPC_PAUSED;
            end
            LPC_PAUSED:
            begin
                if (link && ev_stop)
                    st_nxt = LPC_STOPPED;
                else if (link && ev_pause)
                    st_nxt = LPC_RUNNING;
            end
            LPC_COLLIDED:
            begin
                // resume needs the warning cleared first, then a pause press
                if (link && ev_stop)
                    st_nxt = LPC_STOPPED;
                else if (link && ev_pause && !warn_r)
                    st_nxt = LPC_RUNNING;
            end
            default:
                st_nxt = LPC_OFF;
        endcase
        if (ev_shut)
        begin
            st_nxt = LPC_OFF;
            at_home_nxt = 1'b0;
            alive_nxt = 1'b0;
            wait_nxt = '0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            st_r <= LPC_OFF;
            at_home_r <= 1'b0;
            warn_r <= 1'b0;
            alive_r <= 1'b0;
            wait_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            at_home_r <= at_home_nxt;
            warn_r <= warn_nxt;
            alive_r <= alive_nxt;
            wait_r <= wait_nxt;
        end
    end

    // registered outputs
    logic run_o_r;
    logic stop_o_r;
    logic pause_o_r;
    logic home_o_r;
    logic drag_r;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            run_o_r <= 1'b0;
            stop_o_r <= 1'b0;
            pause_o_r <= 1'b0;
            home_o_r <= 1'b0;
            drag_r <= 1'b0;
        end
        else if (i_ce)
        begin
            run_o_r <= link && st_r == LPC_RUNNING;
            stop_o_r <= link && (st_r == LPC_STOPPED || st_r == LPC_HOMING);
            pause_o_r <= link && (st_r == LPC_PAUSED || st_r == LPC_COLLIDED);
            home_o_r <= link && at_home_r;
            drag_r <= st_r != LPC_OFF && filt_r[`LPC_IN_DRAG];
        end
    end

    assign o_prog_running_out = run_o_r;
    assign o_prog_stopped_out = stop_o_r;
    assign o_prog_paused_out = pause_o_r;
    assign o_at_home_out = home_o_r;
    assign o_sw_alive_out = alive_r;
    assign o_power_en = st_r != LPC_OFF;
    assign o_motion_en = st_r == LPC_RUNNING || st_r == LPC_HOMING;
    assign o_homing = st_r == LPC_HOMING;
    assign o_drag_mode = drag_r;
    assign o_warn_pending = warn_r;
    assign o_host_ready = alive_r && wait_r == '0;

    // interrupts and register port
    logic [`LPC_IRQ_W-1:0] ev_vec;
    logic [`LPC_IRQ_W-1:0] irq_st_r;
    logic [`LPC_IRQ_W-1:0] irq_st_nxt;
    logic [`LPC_IRQ_W-1:0] irq_mask_r;
    logic [`LPC_IRQ_W-1:0] irq_mask_nxt;
    logic [2:0] evc_r;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic [9:0] stat_vec;

    always_comb
    begin
        ev_vec = '0;
        ev_vec[`LPC_IRQ_START] = st_r != LPC_RUNNING && st_nxt == LPC_RUNNING;
        ev_vec[`LPC_IRQ_STOP] = st_r != LPC_STOPPED && st_nxt == LPC_STOPPED;
        ev_vec[`LPC_IRQ_PAUSE] = st_r == LPC_RUNNING && st_nxt == LPC_PAUSED;
        ev_vec[`LPC_IRQ_HOME] = arrive_ev;
        ev_vec[`LPC_IRQ_COLL] = collide_ev;
        ev_vec[`LPC_IRQ_PWR] = st_r == LPC_OFF && st_nxt != LPC_OFF;
        stat_vec = '0;
        stat_vec[`LPC_ST_POWERED] = st_r != LPC_OFF;
        stat_vec[`LPC_ST_ALIVE] = alive_r;
        stat_vec[`LPC_ST_RUN] = run_o_r;
        stat_vec[`LPC_ST_STOP] = stop_o_r;
        stat_vec[`LPC_ST_PAUSE] = pause_o_r;
        stat_vec[`LPC_ST_HOME] = home_o_r;
        stat_vec[`LPC_ST_DRAG] = drag_r;
        stat_vec[`LPC_ST_WARN] = warn_r;
        stat_vec[`LPC_ST_LINK] = link;
        stat_vec[`LPC_ST_READY] = o_host_ready;
        irq_mask_nxt = irq_mask_r;
        if (i_wr && i_addr == `LPC_REG_IRQ_MASK)
            irq_mask_nxt = i_wdata[`LPC_IRQ_W-1:0];
        irq_st_nxt = irq_st_r;
        // read clears, but a new event in the same cycle is kept
        if (i_rd && i_addr == `LPC_REG_IRQ_STAT)
            irq_st_nxt = '0;
        irq_st_nxt = irq_st_nxt | ev_vec;
        rdata_nxt = '0;
        if (i_rd)
        begin
            case (i_addr)
                `LPC_REG_STATUS: rdata_nxt = {22'h0, stat_vec};
                `LPC_REG_IRQ_STAT: rdata_nxt = {26'h0, irq_st_r};
                `LPC_REG_IRQ_MASK: rdata_nxt = {26'h0, irq_mask_r};
                `LPC_REG_EVENTS: rdata_nxt = {29'h0, evc_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    // event register: written collision, arrival and alive bits read back for one cycle only and drive no logic
    logic [2:0] evc_nxt;
    always_comb
    begin
        evc_nxt = '0;
        if (i_wr && i_addr == `LPC_REG_EVENTS)
            evc_nxt = i_wdata[2:0];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            irq_st_r <= '0;
            irq_mask_r <= '0;
            rdata_r <= '0;
            evc_r <= '0;
        end
        else
        begin
            irq_st_r <= irq_st_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
            evc_r <= evc_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = |(irq_st_r & irq_mask_r);

    chk_stop_drops_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_r == LPC_RUNNING && link && ev_stop && !ev_shut) |=> st_r == LPC_STOPPED)
        else $error("stop press did not stop program");
    chk_pause_toggle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_PAUSED && link && ev_pause && !ev_stop && !ev_shut) |=> st_r == LPC_RUNNING)
        else $error("second pause did not resume");
    chk_outs_need_link: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !link) |=> !run_o_r && !stop_o_r && !pause_o_r && !home_o_r)
        else $error("status output outside linkage");
    chk_power_any_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_OFF && ev_pwr_on && !ev_shut) |=> o_power_en)
        else $error("power on ignored");
    chk_shutdown_any: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ev_shut |=> !o_power_en && !o_sw_alive_out)
        else $error("shutdown ignored");
    chk_stopped_after_pwr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_OFF && ev_pwr_on && !ev_shut && link) ##1 (i_ce && link && !ev_shut) |=> stop_o_r)
        else $error("stopped output missing after power on");
    chk_start_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_STOPPED && link && ev_start && !ev_shut) |=> st_r == LPC_RUNNING && !at_home_r)
        else $error("start did not run");
    chk_coll_needs_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_COLLIDED && warn_r && !ev_shut && !ev_stop) |=> st_r == LPC_COLLIDED)
        else $error("resumed before warning clear");
    chk_clear_warn: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (ev_clear && !collide_ev) |=> !warn_r)
        else $error("warning not cleared");
    chk_arrive_home: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r == LPC_HOMING && i_ce && i_home_reached && !ev_shut) |=> at_home_r)
        else $error("arrival not flagged");
    chk_drag_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_r != LPC_OFF && filt_r[`LPC_IN_DRAG]) |=> drag_r)
        else $error("drag mode not entered");

endmodule : lpc_linkage_ctrl

`default_nettype wire

// *** lpc_params.svh ***
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

// input debounce: 10 us at 100 ns per cycle; raise it for switches with long contact bounce
`define LPC_CLK_PERIOD_NS 100
`define LPC_DEBOUNCE_US 10
`define LPC_DEBOUNCE_CYC ((`LPC_DEBOUNCE_US * 1000) / `LPC_CLK_PERIOD_NS)
// host settle time after software alive, 10 s
`define LPC_ALIVE_WAIT_S 10
// divide first: seconds times ns would overflow 32-bit integer arithmetic
`define LPC_ALIVE_WAIT_CYC (`LPC_ALIVE_WAIT_S * (1000000000 / `LPC_CLK_PERIOD_NS))
`define LPC_CNT_W 32
`define LPC_NUM_IN 8

// input vector bit positions
`define LPC_IN_START 0
`define LPC_IN_STOP 1
`define LPC_IN_PAUSE 2
`define LPC_IN_HOME 3
`define LPC_IN_PWR_ON 4
`define LPC_IN_SHUTDOWN 5
`define LPC_IN_CLEAR 6
`define LPC_IN_DRAG 7

// register offsets
`define LPC_REG_STATUS 4'h0
`define LPC_REG_IRQ_STAT 4'h4
`define LPC_REG_IRQ_MASK 4'h8
`define LPC_REG_EVENTS 4'hC

// status and interrupt bit positions
`define LPC_ST_POWERED 0
`define LPC_ST_ALIVE 1
`define LPC_ST_RUN 2
`define LPC_ST_STOP 3
`define LPC_ST_PAUSE 4
`define LPC_ST_HOME 5
`define LPC_ST_DRAG 6
`define LPC_ST_WARN 7
`define LPC_ST_LINK 8
`define LPC_ST_READY 9
`define LPC_IRQ_W 6
`define LPC_IRQ_START 0
`define LPC_IRQ_STOP 1
`define LPC_IRQ_PAUSE 2
`define LPC_IRQ_HOME 3
`define LPC_IRQ_COLL 4
`define LPC_IRQ_PWR 5
`define LPC_EV_COLL 0
`define LPC_EV_ARRIVE 1
`define LPC_EV_ALIVE 2

`endif

// *** lpc_pkg.sv ***
package lpc_pkg;
    typedef enum logic [2:0] {
        LPC_OFF,
        LPC_STOPPED,
        LPC_HOMING,
        LPC_RUNNING,
        LPC_PAUSED,
        LPC_COLLIDED
    } lpc_state_t;
endpackage : lpc_pkg

// *** lpc_switch_panel.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

// external switch panel: momentary keys stay down for a fixed hold, latching keys flip
module lpc_switch_panel #(
    parameter int HOLD_CYC = `LPC_DEBOUNCE_CYC + 50,
    parameter int GLITCH_CYC = `LPC_DEBOUNCE_CYC / 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_btn,
    input wire logic i_btn_vld,
    input wire logic i_glitch,
    input wire logic i_home_hold,
    output logic [7:0] o_pins
);
    int hold_r [8];
    logic [7:0] pins_r;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pins_r <= 8'h00;
            for (int k = 0; k < 8; k++)
                hold_r[k] <= 0;
        end
        else
        begin
            for (int k = 0; k < 8; k++)
            begin
                if (hold_r[k] == 1)
                    pins_r[k] <= 1'b0;
                if (hold_r[k] != 0)
                    hold_r[k] <= hold_r[k] - 1;
            end
            if (i_btn_vld)
            begin
                if (i_btn == 3'(`LPC_IN_PAUSE) || i_btn == 3'(`LPC_IN_DRAG))
                    pins_r[i_btn] <= ~pins_r[i_btn];
                else
                begin
                    pins_r[i_btn] <= 1'b1;
                    // a glitch is released long before the input filter can accept it
                    hold_r[i_btn] <= i_glitch ? GLITCH_CYC : HOLD_CYC;
                end
            end
        end
    end

    always_comb
    begin
        o_pins = pins_r;
        o_pins[`LPC_IN_HOME] = i_home_hold;
    end
endmodule : lpc_switch_panel
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

module tb;
    localparam int FILT = `LPC_DEBOUNCE_CYC + 100;
    localparam int RUN = 0, STP = 1, PAU = 2, HOM = 3, ALV = 4, PWR = 5, HMG = 6, DRG = 7, WRN = 8, IRQ = 9;
    localparam int MOT = 10;
    logic core_clk = 1'b0, rst_n = 1'b0, linkage = 1'b1, sw_ready = 1'b0, coll = 1'b0, reached = 1'b0;
    logic wr = 1'b0, rd = 1'b0, btn_vld = 1'b0, glitch = 1'b0, home_hold = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] btn = 3'h0;
    wire [7:0] pins;
    wire [10:0] obs;
    wire [31:0] rdata;
    int error_cnt = 0;
    int n_checks = 0;

    always #50 core_clk = ~core_clk;

    lpc_linkage_ctrl lpc_linkage_ctrl_i (
        .i_core_clk(core_clk),
        .i_rst_n(rst_n),
        .i_ce(1'b1),
        .i_linkage_mode(linkage),
        .i_prog_start_in(pins[`LPC_IN_START]),
        .i_prog_stop_in(pins[`LPC_IN_STOP]),
        .i_prog_pause_in(pins[`LPC_IN_PAUSE]),
        .i_go_home_in(pins[`LPC_IN_HOME]),
        .i_remote_power_on_in(pins[`LPC_IN_PWR_ON]),
        .i_remote_shutdown_in(pins[`LPC_IN_SHUTDOWN]),
        .i_warn_clear_in(pins[`LPC_IN_CLEAR]),
        .i_drag_teach_en_in(pins[`LPC_IN_DRAG]),
        .i_sw_ready(sw_ready),
        .i_collision(coll),
        .i_home_reached(reached),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .o_irq(obs[IRQ]),
        .o_power_en(obs[PWR]),
        .o_motion_en(obs[MOT]),
        .o_homing(obs[HMG]),
        .o_drag_mode(obs[DRG]),
        .o_warn_pending(obs[WRN]),
        .o_host_ready(),
        .o_prog_running_out(obs[RUN]),
        .o_prog_stopped_out(obs[STP]),
        .o_prog_paused_out(obs[PAU]),
        .o_at_home_out(obs[HOM]),
        .o_sw_alive_out(obs[ALV])
    );

    lpc_switch_panel lpc_switch_panel_i (
        .i_core_clk(core_clk),
        .i_rst_n(rst_n),
        .i_btn(btn),
        .i_btn_vld(btn_vld),
        .i_glitch(glitch),
        .i_home_hold(home_hold),
        .o_pins(pins)
    );

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // polls at the falling edge so the design's updates have landed
    task automatic wait_out(input int k, input logic exp, input int bound, input string name);
        int n;
        n = 1;
        @(negedge core_clk);
        while (obs[k] !== exp && n < bound)
        begin
            @(negedge core_clk);
            n++;
        end
        check(name, {31'h0, obs[k]}, {31'h0, exp});
        if (obs[k] !== exp && bound > 1)
            results();
    endtask : wait_out

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp, input string name);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        check(name, rdata & msk, exp);
    endtask : rd_chk

    task automatic press(input int b, input logic g);
        @(posedge core_clk);
        btn <= 3'(b);
        glitch <= g;
        btn_vld <= 1'b1;
        @(posedge core_clk);
        btn_vld <= 1'b0;
    endtask : press

    task automatic sc_regs();
        rd_chk(`LPC_REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "mask_reset");
        reg_wr(4'h2, 32'hFFFFFFFF);
        rd_chk(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
        wait_out(PWR, 1'b0, 1, "power_reset");
    endtask : sc_regs

    task automatic sc_power_on();
        press(`LPC_IN_PWR_ON, 1'b0);
        wait_out(PWR, 1'b1, FILT, "power_on");
        wait_out(STP, 1'b1, 3, "stopped_after_power");
        @(posedge core_clk);
        sw_ready <= 1'b1;
        wait_out(ALV, 1'b1, 4, "sw_alive");
        wait_out(IRQ, 1'b0, 1, "irq_masked");
        rd_chk(`LPC_REG_IRQ_STAT, 32'h20, 32'h20, "irq_power");
        reg_wr(`LPC_REG_IRQ_MASK, 32'h3F);
        rd_chk(`LPC_REG_IRQ_MASK, 32'hFFFFFFFF, 32'h3F, "mask_rw");
    endtask : sc_power_on

    task automatic sc_home();
        @(posedge core_clk);
        home_hold <= 1'b1;
        wait_out(HMG, 1'b1, FILT, "homing");
        wait_out(HOM, 1'b0, 1, "home_before_arrival");
        @(posedge core_clk);
        reached <= 1'b1;
        wait_out(HOM, 1'b1, 4, "at_home");
        wait_out(IRQ, 1'b1, 3, "irq_raised");
        rd_chk(`LPC_REG_IRQ_STAT, 32'h08, 32'h08, "irq_arrival");
        wait_out(IRQ, 1'b0, 1, "irq_cleared");
        @(posedge core_clk);
        home_hold <= 1'b0;
        reached <= 1'b0;
    endtask : sc_home

    task automatic sc_start();
        press(`LPC_IN_START, 1'b0);
        wait_out(RUN, 1'b1, FILT, "running");
        wait_out(STP, 1'b0, 1, "stopped_off");
        wait_out(HOM, 1'b0, 1, "home_off");
        wait_out(MOT, 1'b1, 1, "motion_on");
        // powered, alive, running, linkage
        rd_chk(`LPC_REG_STATUS, 32'hFFFFFFFF, 32'h107, "status");
        rd_chk(`LPC_REG_IRQ_STAT, 32'hFFFFFFFF, 32'h01, "irq_start");
    endtask : sc_start

    task automatic sc_glitch();
        press(`LPC_IN_STOP, 1'b1);
        repeat (FILT) @(negedge core_clk);
        wait_out(RUN, 1'b1, 1, "glitch_ignored");
    endtask : sc_glitch

    task automatic sc_pause();
        press(`LPC_IN_PAUSE, 1'b0);
        wait_out(PAU, 1'b1, FILT, "paused");
        wait_out(RUN, 1'b0, 1, "run_off_paused");
        press(`LPC_IN_PAUSE, 1'b0);
        wait_out(RUN, 1'b1, FILT, "resumed");
        wait_out(PAU, 1'b0, 1, "pause_off");
    endtask : sc_pause

    task automatic sc_collision();
        @(posedge core_clk);
        coll <= 1'b1;
        @(posedge core_clk);
        coll <= 1'b0;
        wait_out(PAU, 1'b1, 4, "coll_paused");
        wait_out(RUN, 1'b0, 1, "coll_run_off");
        wait_out(WRN, 1'b1, 1, "warn_set");
        // resuming before the warning is cleared must be refused
        press(`LPC_IN_PAUSE, 1'b0);
        repeat (FILT) @(negedge core_clk);
        wait_out(PAU, 1'b1, 1, "resume_refused");
        press(`LPC_IN_CLEAR, 1'b0);
        wait_out(WRN, 1'b0, FILT, "warn_cleared");
        press(`LPC_IN_PAUSE, 1'b0);
        wait_out(RUN, 1'b1, FILT, "coll_resumed");
        wait_out(PAU, 1'b0, 1, "coll_pause_off");
    endtask : sc_collision

    task automatic sc_stop();
        press(`LPC_IN_STOP, 1'b0);
        wait_out(STP, 1'b1, FILT, "stopped");
        wait_out(RUN, 1'b0, 1, "stop_run_off");
        wait_out(MOT, 1'b0, 1, "motion_off");
    endtask : sc_stop

    task automatic sc_drag();
        press(`LPC_IN_DRAG, 1'b0);
        wait_out(DRG, 1'b1, FILT, "drag_on");
        press(`LPC_IN_DRAG, 1'b0);
        wait_out(DRG, 1'b0, FILT, "drag_off");
    endtask : sc_drag

    task automatic sc_outside();
        @(posedge core_clk);
        linkage <= 1'b0;
        repeat (3) @(negedge core_clk);
        check("status_outside", {28'h0, obs[3:0]}, 32'h0);
        press(`LPC_IN_START, 1'b0);
        repeat (FILT) @(negedge core_clk);
        @(posedge core_clk);
        linkage <= 1'b1;
        repeat (3) @(negedge core_clk);
        check("start_ignored", {28'h0, obs[3:0]}, 32'h2);
    endtask : sc_outside

    task automatic sc_remote();
        @(posedge core_clk);
        linkage <= 1'b0;
        press(`LPC_IN_SHUTDOWN, 1'b0);
        wait_out(PWR, 1'b0, FILT, "shutdown");
        press(`LPC_IN_PWR_ON, 1'b0);
        wait_out(PWR, 1'b1, FILT, "power_on_outside");
    endtask : sc_remote

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        sc_regs();
        sc_power_on();
        sc_home();
        sc_start();
        sc_glitch();
        sc_pause();
        sc_collision();
        sc_stop();
        sc_drag();
        sc_outside();
        sc_remote();
        results();
    end
endmodule : tb
`default_nettype wire
